// ### src/mode_and_system_control.sv
// The plain strobed port and the address map were left to the implementer.
module mode_and_system_control (
    // clock and reset
    input  wire logic                              clock,
    input  wire logic                              nrst,
    // register port
    input  wire logic [mode_ctrl_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [mode_ctrl_pkg::DATA_W-1:0]  regWriteData,
    input  wire logic                              regWrite,
    input  wire logic                              regRead,
    output logic      [mode_ctrl_pkg::DATA_W-1:0]  regReadData,
    // mode select pins
    input  wire logic [mode_ctrl_pkg::MODE_PINS_W-1:0] modeSelectPin,
    // mode status
    output logic      [mode_ctrl_pkg::MODE_PINS_W-1:0] modeLatch,
    output logic                                   modeLatchValid,
    output logic                                   supportedMode,
    // system configuration
    output logic                                   multiplyAccSaturate,
    output logic      [1:0]                        irqControlMode,
    output logic                                   nonmaskableEdgeSelect,
    output logic                                   onchipRamEnable,
    // mode dependent chip setup
    output logic                                   advancedAddressing,
    output logic                                   onchipRomEnable,
    output logic                                   externalBusEnable,
    output logic                                   portGeneralPurpose
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [mode_ctrl_pkg::MODE_PINS_W-1:0] pinLevel;
    logic                                  modeRsv_reg;
    logic                                  modeRsv_next;
    logic                                  sat_reg;
    logic                                  sat_next;
    logic [1:0]                            irqMode_reg;
    logic [1:0]                            irqMode_next;
    logic                                  nmiEdge_reg;
    logic                                  nmiEdge_next;
    logic                                  ramEn_reg;
    logic                                  ramEn_next;
    logic [mode_ctrl_pkg::DATA_W-1:0]      readData_reg;
    logic [mode_ctrl_pkg::DATA_W-1:0]      readData_next;
    logic                                  supported_reg;
    logic                                  romEn_reg;
    logic                                  extBus_reg;
    logic                                  gpio_reg;
    logic                                  advAddr_reg;
    logic                                  selMode;
    logic                                  selConfig;
    logic                                  wrMode;
    logic                                  wrConfig;
    logic                                  rdMode;
    logic [1:0]                            wrIrqField;
    logic                                  irqFieldLegal;
    logic [mode_ctrl_pkg::DATA_W-1:0]      modeImage;
    logic [mode_ctrl_pkg::DATA_W-1:0]      configImage;

    // ----------------------------------------
    // mode pin synchroniser
    // ----------------------------------------
    pin_sync #(
        .WIDTH   (mode_ctrl_pkg::MODE_PINS_W)
    ) u_pin_sync (
        .clock   (clock),
        .nrst    (nrst),
        .pinIn   (modeSelectPin),
        .pinSync (pinLevel)
    );

    // ----------------------------------------
    // mode latch, captured by software reads
    // ----------------------------------------
    mode_latch #(
        .WIDTH      (mode_ctrl_pkg::MODE_PINS_W)
    ) u_mode_latch (
        .clock      (clock),
        .nrst       (nrst),
        .capture    (rdMode),
        .levelIn    (pinLevel),
        .latched    (modeLatch),
        .latchValid (modeLatchValid)
    );

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // a single decode function keeps read and write maps identical
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign selMode   = hit(regAddr, mode_ctrl_pkg::MODE_READBACK_OFS);
    assign selConfig = hit(regAddr, mode_ctrl_pkg::SYSTEM_CONFIG_OFS);
    assign wrMode    = regWrite && selMode;
    assign wrConfig  = regWrite && selConfig;
    assign rdMode    = regRead && selMode;

    // ----------------------------------------
    // write side, next values
    // ----------------------------------------
    // only the reserved bit takes a write; mode bits are untouched
    assign modeRsv_next = wrMode ? regWriteData[mode_ctrl_pkg::MODE_RSV_BIT]
                                 : modeRsv_reg;

    assign sat_next = wrConfig ? regWriteData[mode_ctrl_pkg::SAT_BIT]
                               : sat_reg;

    // prohibited codes are refused so the controller never sees them
    assign wrIrqField    = regWriteData[mode_ctrl_pkg::IRQ_MODE_HI:mode_ctrl_pkg::IRQ_MODE_LO];
    assign irqFieldLegal = (wrIrqField == mode_ctrl_pkg::IRQ_MODE_0)
                        || (wrIrqField == mode_ctrl_pkg::IRQ_MODE_2);
    assign irqMode_next  = (wrConfig && irqFieldLegal) ? wrIrqField
                                                       : irqMode_reg;

    assign nmiEdge_next = wrConfig ? regWriteData[mode_ctrl_pkg::NMI_EDGE_BIT]
                                   : nmiEdge_reg;

    assign ramEn_next = wrConfig ? regWriteData[mode_ctrl_pkg::RAM_EN_BIT]
                                 : ramEn_reg;

    // ----------------------------------------
    // read side images
    // ----------------------------------------
    // mode bits show the levels being captured by this very read
    always_comb begin
        modeImage = '0;
        modeImage[mode_ctrl_pkg::MODE_RSV_BIT] = modeRsv_reg;
        modeImage[mode_ctrl_pkg::MODE_LATCH_HI:0] = pinLevel;
    end

    // reserved configuration bits are never stored, so read zero
    always_comb begin
        configImage = '0;
        configImage[mode_ctrl_pkg::SAT_BIT] = sat_reg;
        configImage[mode_ctrl_pkg::IRQ_MODE_HI:mode_ctrl_pkg::IRQ_MODE_LO] = irqMode_reg;
        configImage[mode_ctrl_pkg::NMI_EDGE_BIT] = nmiEdge_reg;
        configImage[mode_ctrl_pkg::RAM_EN_BIT] = ramEn_reg;
    end

    // read mux, unmapped addresses answer zero
    always_comb begin
        if (!regRead) begin
            readData_next = mode_ctrl_pkg::UNMAPPED_DATA;
        end else if (selMode) begin
            readData_next = modeImage;
        end else if (selConfig) begin
            readData_next = configImage;
        end else begin
            readData_next = mode_ctrl_pkg::UNMAPPED_DATA;
        end
    end

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            modeRsv_reg <= mode_ctrl_pkg::MODE_RSV_RESET;
            sat_reg     <= mode_ctrl_pkg::SAT_RESET;
            irqMode_reg <= mode_ctrl_pkg::IRQ_MODE_0;
            nmiEdge_reg <= mode_ctrl_pkg::NMI_EDGE_RESET;
            ramEn_reg   <= mode_ctrl_pkg::RAM_EN_RESET;
        end else begin
            modeRsv_reg <= modeRsv_next;
            sat_reg     <= sat_next;
            irqMode_reg <= irqMode_next;
            nmiEdge_reg <= nmiEdge_next;
            ramEn_reg   <= ramEn_next;
        end
    end

    // read data stands for exactly one cycle after the strobe
    always_ff @(posedge clock) begin
        if (!nrst) begin
            readData_reg <= mode_ctrl_pkg::UNMAPPED_DATA;
        end else begin
            readData_reg <= readData_next;
        end
    end

    // ----------------------------------------
    // mode dependent chip setup
    // ----------------------------------------
    // only one mode exists, so the setup outputs are fixed whatever the pins; only supportedMode follows the pin check
    always_ff @(posedge clock) begin
        if (!nrst) begin
            supported_reg <= 1'b0;
            advAddr_reg   <= 1'b0;
            romEn_reg     <= 1'b0;
            extBus_reg    <= 1'b0;
            gpio_reg      <= 1'b0;
        end else begin
            supported_reg <= (pinLevel == mode_ctrl_pkg::MODE_SUPPORTED);
            advAddr_reg   <= 1'b1;
            romEn_reg     <= 1'b1;
            extBus_reg    <= 1'b0;
            gpio_reg      <= 1'b1;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign regReadData           = readData_reg;
    assign supportedMode         = supported_reg;
    assign multiplyAccSaturate   = sat_reg;
    assign irqControlMode        = irqMode_reg;
    assign nonmaskableEdgeSelect = nmiEdge_reg;
    assign onchipRamEnable       = ramEn_reg;
    assign advancedAddressing    = advAddr_reg;
    assign onchipRomEnable       = romEn_reg;
    assign externalBusEnable     = extBus_reg;
    assign portGeneralPurpose    = gpio_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_readMode;
        regRead && selMode;
    endsequence

    sequence s_writeConfig;
        regWrite && selConfig;
    endsequence

    property p_modeZeroBits;
        s_readMode |=> regReadData[mode_ctrl_pkg::MODE_ZERO_HI:mode_ctrl_pkg::MODE_ZERO_LO] == '0;
    endproperty
    a_modeZeroBits: assert property (p_modeZeroBits) else $error("mode reserved bits not zero");

    property p_modeCapture;
        s_readMode |=> (modeLatch == $past(pinLevel)) && modeLatchValid
                       && regReadData[mode_ctrl_pkg::MODE_LATCH_HI:0] == modeLatch;
    endproperty
    a_modeCapture: assert property (p_modeCapture) else $error("mode pins not latched on read");

    property p_modeReadOnly;
        (regWrite && selMode) |=> $stable(modeLatch);
    endproperty
    a_modeReadOnly: assert property (p_modeReadOnly) else $error("mode bits changed by write");

    property p_resetRelease;
        $rose(nrst) |-> !modeLatchValid && modeLatch == mode_ctrl_pkg::MODE_LATCH_RESET
                        && irqControlMode == mode_ctrl_pkg::IRQ_MODE_0 && onchipRamEnable;
    endproperty
    a_resetRelease: assert property (@(posedge clock) p_resetRelease)
        else $error("bad state after reset release");

    property p_irqLegal;
        irqControlMode == mode_ctrl_pkg::IRQ_MODE_0 || irqControlMode == mode_ctrl_pkg::IRQ_MODE_2;
    endproperty
    a_irqLegal: assert property (p_irqLegal) else $error("prohibited irq control mode");

    property p_configWrite;
        s_writeConfig |=> multiplyAccSaturate == $past(regWriteData[mode_ctrl_pkg::SAT_BIT])
                          && nonmaskableEdgeSelect == $past(regWriteData[mode_ctrl_pkg::NMI_EDGE_BIT])
                          && onchipRamEnable == $past(regWriteData[mode_ctrl_pkg::RAM_EN_BIT]);
    endproperty
    a_configWrite: assert property (p_configWrite) else $error("config write not stored");

    // reserved positions sit between the stored fields, so they are named from their neighbours
    property p_configZeroBits;
        (regRead && selConfig) |=> regReadData[mode_ctrl_pkg::SAT_BIT-1] == 1'b0
            && regReadData[mode_ctrl_pkg::NMI_EDGE_BIT-1:mode_ctrl_pkg::RAM_EN_BIT+1] == '0
            && regReadData[mode_ctrl_pkg::RAM_EN_BIT] == onchipRamEnable;
    endproperty
    a_configZeroBits: assert property (p_configZeroBits) else $error("config read wrong");

    property p_supported;
        (pinLevel == mode_ctrl_pkg::MODE_SUPPORTED) [*2] |-> supportedMode;
    endproperty
    a_supported: assert property (p_supported) else $error("supported mode not flagged");

    property p_setup;
        $past(nrst) |-> onchipRomEnable && !externalBusEnable && portGeneralPurpose && advancedAddressing;
    endproperty
    a_setup: assert property (p_setup) else $error("chip setup wrong");

    // a prohibited code must leave the controller in its previous mode
    property p_irqRefused;
        (regWrite && selConfig && !irqFieldLegal) |=> $stable(irqControlMode);
    endproperty
    a_irqRefused: assert property (p_irqRefused) else $error("prohibited irq code stored");

    // reserved mode bit keeps whatever software wrote
    property p_modeRsvWrite;
        (regWrite && selMode) |=> modeRsv_reg == $past(regWriteData[mode_ctrl_pkg::MODE_RSV_BIT]);
    endproperty
    a_modeRsvWrite: assert property (p_modeRsvWrite) else $error("reserved mode bit not stored");

endmodule // mode_and_system_control

// ### common/mode_ctrl_pkg.sv
package mode_ctrl_pkg;

    // ----------------------------------------
    // register bus shape
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] MODE_READBACK_OFS = 8'h00;
    localparam logic [7:0] SYSTEM_CONFIG_OFS = 8'h01;
    localparam logic [7:0] UNMAPPED_DATA     = 8'h00;

    // ----------------------------------------
    // mode readback register layout
    // ----------------------------------------
    localparam int         MODE_RSV_BIT   = 7;
    localparam int         MODE_ZERO_HI   = 6;
    localparam int         MODE_ZERO_LO   = 3;
    localparam int         MODE_LATCH_HI  = 2;
    localparam logic       MODE_RSV_RESET = 1'b1;
    localparam int         MODE_PINS_W    = 3;
    localparam logic [2:0] MODE_LATCH_RESET = 3'h0;
    localparam logic [2:0] MODE_SUPPORTED = 3'h7;

    // ----------------------------------------
    // system configuration register layout
    // ----------------------------------------
    localparam int         SAT_BIT      = 7;
    localparam int         IRQ_MODE_HI  = 5;
    localparam int         IRQ_MODE_LO  = 4;
    localparam int         NMI_EDGE_BIT = 3;
    localparam int         RAM_EN_BIT   = 0;
    localparam logic       SAT_RESET      = 1'b0;
    localparam logic [1:0] IRQ_MODE_0     = 2'h0;
    localparam logic [1:0] IRQ_MODE_2     = 2'h2;
    localparam logic       NMI_EDGE_RESET = 1'b0;
    localparam logic       RAM_EN_RESET   = 1'b1;

    // ----------------------------------------
    // addressing in the supported mode
    // ----------------------------------------
    localparam int ADDR_SPACE_MBYTE = 16;
    localparam int CPU_ADDR_W       = $clog2(ADDR_SPACE_MBYTE * 1024 * 1024);

endpackage

// ### src/pin_sync.sv
module pin_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // ----------------------------------------
    // two flops per pin, first stage read only by second
    // ----------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock) begin
            if (!nrst) begin
                stage1_reg[i] <= 1'b0;
                stage2_reg[i] <= 1'b0;
            end else begin
                stage1_reg[i] <= pinIn[i];
                stage2_reg[i] <= stage1_reg[i];
            end
        end
    end

    assign pinSync = stage2_reg;

endmodule // pin_sync

// ### src/mode_latch.sv
module mode_latch #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // capture request and levels
    input  wire logic             capture,
    input  wire logic [WIDTH-1:0] levelIn,
    // latched levels
    output logic      [WIDTH-1:0] latched,
    output logic                  latchValid
);

    logic [WIDTH-1:0] latch_reg;
    logic             valid_reg;

    // ----------------------------------------
    // capture on read, released by reset
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            latch_reg <= mode_ctrl_pkg::MODE_LATCH_RESET;
            valid_reg <= 1'b0;
        end else if (capture) begin
            latch_reg <= levelIn;
            valid_reg <= 1'b1;
        end
    end

    assign latched    = latch_reg;
    assign latchValid = valid_reg;

endmodule // mode_latch

// ### testbench/mode_and_system_control_test.sv
module mode_and_system_control_test;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic       clock         = 1'b0;
    logic       nrst          = 1'b0;
    logic [7:0] regAddr       = 8'h00;
    logic [7:0] regWriteData  = 8'h00;
    logic       regWrite      = 1'b0;
    logic       regRead       = 1'b0;
    logic [2:0] modeSelectPin = 3'h7;
    logic [7:0] regReadData;
    logic [2:0] modeLatch;
    logic       modeLatchValid;
    logic       supportedMode;
    logic       multiplyAccSaturate;
    logic [1:0] irqControlMode;
    logic       nonmaskableEdgeSelect;
    logic       onchipRamEnable;
    logic       advancedAddressing;
    logic       onchipRomEnable;
    logic       externalBusEnable;
    logic       portGeneralPurpose;
    logic [7:0] rd;
    int         fails       = 0;
    int         totalChecks = 0;

    // config writes and what must read back: prohibited irq codes hold the field
    localparam logic [7:0] CFG_IN  [7] = '{8'hFF, 8'h20, 8'h10, 8'h30, 8'h00, 8'h4E, 8'h81};
    localparam logic [7:0] CFG_EXP [7] = '{8'h89, 8'h20, 8'h20, 8'h20, 8'h00, 8'h08, 8'h81};

    // ----------------------------------------
    // design under test
    // ----------------------------------------
    mode_and_system_control mode_and_system_control_i (
        .clock                 (clock),
        .nrst                  (nrst),
        .regAddr               (regAddr),
        .regWriteData          (regWriteData),
        .regWrite              (regWrite),
        .regRead               (regRead),
        .regReadData           (regReadData),
        .modeSelectPin         (modeSelectPin),
        .modeLatch             (modeLatch),
        .modeLatchValid        (modeLatchValid),
        .supportedMode         (supportedMode),
        .multiplyAccSaturate   (multiplyAccSaturate),
        .irqControlMode        (irqControlMode),
        .nonmaskableEdgeSelect (nonmaskableEdgeSelect),
        .onchipRamEnable       (onchipRamEnable),
        .advancedAddressing    (advancedAddressing),
        .onchipRomEnable       (onchipRomEnable),
        .externalBusEnable     (externalBusEnable),
        .portGeneralPurpose    (portGeneralPurpose)
    );

    // 10 MHz system clock
    initial begin
        forever #50 clock = ~clock;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // one compare; four-state so an unknown never matches
    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        totalChecks++;
        if (seen !== expected) begin
            fails++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expected);
        end
    endtask

    // write strobe for one cycle, then one idle edge so no strobe is set twice per step
    task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
        regAddr      <= addr;
        regWriteData <= data;
        regWrite     <= 1'b1;
        @(posedge clock);
        regWrite     <= 1'b0;
        @(posedge clock);
    endtask

    // read data is taken in the cycle after the strobe, then must fall back to zero
    task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
        regAddr <= addr;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 data = regReadData;
        @(posedge clock);
        #1 check(regReadData, 8'h00);
        @(posedge clock);
    endtask

    // pins only move while reset is held, never during operation
    task automatic doReset(input logic [2:0] pins);
        nrst          <= 1'b0;
        modeSelectPin <= pins;
        repeat (20) @(posedge clock);
        #1 check(modeLatch, 3'h0);
        check(modeLatchValid, 1'b0);
        check(multiplyAccSaturate, 1'b0);
        check(irqControlMode, mode_ctrl_pkg::IRQ_MODE_0);
        check(nonmaskableEdgeSelect, 1'b0);
        check(onchipRamEnable, 1'b1);
        @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        #1 check(advancedAddressing, 1'b1);
        check(onchipRomEnable, 1'b1);
        check(externalBusEnable, 1'b0);
        check(portGeneralPurpose, 1'b1);
        @(posedge clock);
    endtask

    // verdict in one place
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        // board holds every mode pin high
        doReset(3'h7);
        readReg(mode_ctrl_pkg::SYSTEM_CONFIG_OFS, rd);
        check(rd, 8'h01);
        readReg(mode_ctrl_pkg::MODE_READBACK_OFS, rd);
        check(rd, 8'h87);
        check(modeLatch, 3'h7);
        check(modeLatchValid, 1'b1);
        check(supportedMode, 1'b1);

        // every config field, reserved bits and prohibited irq codes
        for (int i = 0; i < 7; i++) begin
            writeReg(mode_ctrl_pkg::SYSTEM_CONFIG_OFS, CFG_IN[i]);
            check(multiplyAccSaturate, CFG_EXP[i][7]);
            check(irqControlMode, CFG_EXP[i][5:4]);
            check(nonmaskableEdgeSelect, CFG_EXP[i][3]);
            check(onchipRamEnable, CFG_EXP[i][0]);
            readReg(mode_ctrl_pkg::SYSTEM_CONFIG_OFS, rd);
            check(rd, CFG_EXP[i]);
        end

        // mode register: zero bits and pin bits ignore writes, bit 7 kept at one
        writeReg(mode_ctrl_pkg::MODE_READBACK_OFS, 8'hF8);
        check(modeLatch, 3'h7);
        readReg(mode_ctrl_pkg::MODE_READBACK_OFS, rd);
        check(rd, 8'h87);

        // unmapped place: write ignored, read zero
        writeReg(8'h7F, 8'hFF);
        readReg(8'h7F, rd);
        check(rd, mode_ctrl_pkg::UNMAPPED_DATA);
        readReg(mode_ctrl_pkg::SYSTEM_CONFIG_OFS, rd);
        check(rd, 8'h81);

        // second reset with an unsupported pin pattern
        doReset(3'h5);
        readReg(mode_ctrl_pkg::SYSTEM_CONFIG_OFS, rd);
        check(rd, 8'h01);
        readReg(mode_ctrl_pkg::MODE_READBACK_OFS, rd);
        check(rd, 8'h85);
        check(modeLatch, 3'h5);
        check(supportedMode, 1'b0);
        endOfTest();
    end

    // watchdog: the tests need well under 300 cycles
    initial begin
        repeat (3000) @(posedge clock);
        fails++;
        endOfTest();
    end

endmodule // mode_and_system_control_test
